// [src/acb_pkg.sv]
/*
 * constants, field layouts and types of the channel/setup register bank.
 * assumes a single compile unit; no timescale, no logic here.
 */
package acb_pkg;
  localparam int            NUM_CH      = 4;
  localparam int            NUM_SETUP   = 4;
  localparam logic [4:0]    CMD_BITS    = 5'h08;
  localparam int            CMD_WEN_BIT = 7;
  localparam int            CMD_RD_BIT  = 6;
  localparam logic [6:0]    ONES_LAST   = 7'h3f;
  localparam logic [1:0]    LAST_CH     = 2'h3;
  localparam logic [4:0]    LEN8        = 5'h08;
  localparam logic [4:0]    LEN16       = 5'h10;
  localparam logic [4:0]    LEN24       = 5'h18;
  // ********************************
  // register addresses
  // ********************************
  localparam logic [5:0]    ADDR_MODE   = 6'h01;
  localparam logic [5:0]    ADDR_IFMODE = 6'h02;
  localparam logic [5:0]    ADDR_ID     = 6'h07;
  localparam logic [5:0]    ADDR_CH0    = 6'h10;
  localparam logic [5:0]    ADDR_SETUP0 = 6'h20;
  localparam logic [5:0]    ADDR_FILT0  = 6'h28;
  localparam logic [5:0]    ADDR_OFFS0  = 6'h30;
  localparam logic [5:0]    ADDR_SETUP_ZERO_GAIN_COEFFICIENT  = 6'h38;
  // ********************************
  // reset values and writable bits
  // ********************************
  localparam logic [15:0]   CH0_RST     = 16'h8001;
  localparam logic [15:0]   CHN_RST     = 16'h0001;
  localparam logic [15:0]   CH_MASK     = 16'hf3ff;
  localparam int            CH_EN_BIT   = 15;
  localparam logic [15:0]   SETUP_RST   = 16'h1000;
  localparam logic [15:0]   SETUP_MASK  = 16'h1030;
  localparam logic [15:0]   FILT_RST    = 16'h0000;
  localparam logic [15:0]   FILT_MASK   = 16'h8f7f;
  localparam logic [23:0]   OFFS_RST    = 24'h800000;
  localparam logic [15:0]   MODE_RST    = 16'h8000;
  localparam logic [15:0]   MODE_MASK   = 16'ha77c;
  localparam logic [15:0]   IFMODE_RST  = 16'h0000;
  localparam logic [15:0]   IFMODE_MASK = 16'h1ded;

  typedef enum logic {ACB_CMD, ACB_DATA} acb_phase_t;
endpackage : acb_pkg

// [src/acb_sync.sv]
/*
 * two-flop synchroniser for levels and toggles.
 * assumes each bit changes at most once per few destination clocks.
 */
`timescale 1ns/1ns
`default_nettype none
module acb_sync #(
  parameter int W = 1
) (
  // clock and reset of the destination domain
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule : acb_sync
`default_nettype wire

// [src/acb_bank.sv]
/*
 * serial-port register bank with channel sequencer.
 * assumes mode 3 serial link on sclk_i, system clock clk_i, and a
 * converter that pulses conv_done_i and delivers calibration words.
 */
`timescale 1ns/1ns
`default_nettype none
module acb_bank
  import acb_pkg::*;
#(
  parameter logic [15:0] ID_CODE   = 16'h0a50, // arbitrary value
  parameter logic [23:0] GAIN_FACT = 24'h500000
) (
  // system clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial link
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // sequencer
  input  wire logic        conv_done_i,
  output logic [1:0]       active_ch_o,
  output logic             active_valid_o,
  // calibration results
  input  wire logic        cal_req_i,
  input  wire logic        cal_gain_i,
  input  wire logic [1:0]  cal_setup_i,
  input  wire logic [23:0] cal_value_i,
  output logic             cal_busy_o
);
  // ********************************
  // link domain state
  // ********************************
  logic [15:0] ch_reg    [NUM_CH];
  logic [15:0] setup_reg [NUM_SETUP];
  logic [15:0] filt_reg  [NUM_SETUP];
  logic [23:0] offs_reg  [NUM_SETUP];
  logic [23:0] gain_reg  [NUM_SETUP];
  logic [15:0] mode_reg;
  logic [15:0] ifmode_reg;
  acb_phase_t  phase_reg;
  logic [4:0]  cnt_reg;
  logic [4:0]  len_reg;
  logic        rd_reg;
  logic [5:0]  addr_reg;
  logic [23:0] sh_reg;
  logic [23:0] tx_reg;
  logic [6:0]  ones_reg;
  logic [23:0] sh_next;
  logic [23:0] look_word;
  logic [4:0]  look_len;
  logic        rst_s;
  logic        full_rst;
  logic        bank_rst;
  logic        wr_fire;
  logic        cmd_done;
  logic        data_done;
  logic        cal_tog_s;
  logic        cal_seen_reg;
  logic        cal_fire;
  logic        full_tog_reg;
  // ********************************
  // system domain state
  // ********************************
  logic        cal_tog_reg;
  logic        cal_gain_reg;
  logic [1:0]  cal_setup_reg;
  logic [23:0] cal_val_reg;
  logic        cal_ack_s;
  logic        full_tog_s;
  logic        full_seen_reg;
  logic [3:0]  en_s;
  logic [3:0]  ch_en;
  logic [1:0]  cur_reg;
  logic        valid_reg;

  // ********************************
  // crossings
  // ********************************
  // the reset synchroniser itself cannot be reset
  acb_sync #(.W(1)) u_rst_sync (
    .clk_i (sclk_i), .rst_i (1'b0), .d_i (rst_i), .q_o (rst_s)
  );
  acb_sync #(.W(1)) u_cal_sync (
    .clk_i (sclk_i), .rst_i (rst_s), .d_i (cal_tog_reg), .q_o (cal_tog_s)
  );
  acb_sync #(.W(1)) u_ack_sync (
    .clk_i (clk_i), .rst_i (rst_i), .d_i (cal_seen_reg), .q_o (cal_ack_s)
  );
  acb_sync #(.W(1)) u_full_sync (
    .clk_i (clk_i), .rst_i (rst_i), .d_i (full_tog_reg), .q_o (full_tog_s)
  );
  acb_sync #(.W(4)) u_en_sync (
    .clk_i (clk_i), .rst_i (rst_i), .d_i (ch_en), .q_o (en_s)
  );

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_en[i] = ch_reg[i][CH_EN_BIT];
    end
  end

  // ********************************
  // serial port
  // ********************************
  assign sh_next   = {sh_reg[22:0], mosi_i};
  assign full_rst  = (ones_reg == ONES_LAST) && mosi_i;
  assign bank_rst  = rst_s || full_rst;
  assign cmd_done  = (phase_reg == ACB_CMD) && (cnt_reg == CMD_BITS - 5'h01);
  assign data_done = (phase_reg == ACB_DATA) && (cnt_reg == len_reg - 5'h01);
  assign wr_fire   = data_done && !rd_reg;
  assign miso_oe_o = !cs_n_i;

  // read word, left aligned, for the address closing the command byte
  always_comb begin
    logic [5:0] a;
    a         = sh_next[5:0];
    look_word = '0;
    look_len  = LEN8;
    if (a == ADDR_MODE) begin
      look_word = {mode_reg, 8'h00};
      look_len  = LEN16;
    end else if (a == ADDR_IFMODE) begin
      look_word = {ifmode_reg, 8'h00};
      look_len  = LEN16;
    end else if (a == ADDR_ID) begin
      look_word = {ID_CODE, 8'h00};
      look_len  = LEN16;
    end else if (a[5:2] == ADDR_CH0[5:2]) begin
      look_word = {ch_reg[a[1:0]], 8'h00};
      look_len  = LEN16;
    end else if (a[5:2] == ADDR_SETUP0[5:2]) begin
      look_word = {setup_reg[a[1:0]], 8'h00};
      look_len  = LEN16;
    end else if (a[5:2] == ADDR_FILT0[5:2]) begin
      look_word = {filt_reg[a[1:0]], 8'h00};
      look_len  = LEN16;
    end else if (a[5:2] == ADDR_OFFS0[5:2]) begin
      look_word = offs_reg[a[1:0]];
      look_len  = LEN24;
    end else if (a[5:2] == ADDR_SETUP_ZERO_GAIN_COEFFICIENT[5:2]) begin
      look_word = gain_reg[a[1:0]];
      look_len  = LEN24;
    end
  end

  // chip select high is the frame's own end, so it clears asynchronously
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      phase_reg <= ACB_CMD;
      cnt_reg   <= '0;
      len_reg   <= LEN8;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
      sh_reg    <= '0;
      tx_reg    <= '0;
      ones_reg  <= '0;
    end else if (bank_rst) begin
      phase_reg <= ACB_CMD;
      cnt_reg   <= '0;
      len_reg   <= LEN8;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
      sh_reg    <= '0;
      tx_reg    <= '0;
      ones_reg  <= '0;
    end else begin
      ones_reg <= mosi_i ? ones_reg + 7'h01 : '0;
      sh_reg   <= sh_next;
      tx_reg   <= {tx_reg[22:0], 1'b0};
      cnt_reg  <= cnt_reg + 5'h01;
      if (cmd_done) begin
        cnt_reg <= '0;
        // a set write-enable bit is not a command; keep hunting
        if (!sh_next[CMD_WEN_BIT]) begin
          phase_reg <= ACB_DATA;
          rd_reg    <= sh_next[CMD_RD_BIT];
          addr_reg  <= sh_next[5:0];
          len_reg   <= look_len;
          tx_reg    <= look_word;
        end
      end else if (data_done) begin
        phase_reg <= ACB_CMD;
        cnt_reg   <= '0;
      end
    end
  end

  // data out changes on the falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_o <= 1'b0;
    end else begin
      miso_o <= (phase_reg == ACB_DATA) && rd_reg && tx_reg[23];
    end
  end

  // ********************************
  // register bank
  // ********************************
  // calibration lands after a host write, so it wins a same-edge clash
  always_ff @(posedge sclk_i) begin
    if (bank_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_reg[i] <= (i == 0) ? CH0_RST : CHN_RST;
      end
      for (int i = 0; i < NUM_SETUP; i++) begin
        setup_reg[i] <= SETUP_RST;
        filt_reg[i]  <= FILT_RST;
        offs_reg[i]  <= OFFS_RST;
        gain_reg[i]  <= GAIN_FACT;
      end
      mode_reg   <= MODE_RST;
      ifmode_reg <= IFMODE_RST;
    end else begin
      if (wr_fire) begin
        if (addr_reg == ADDR_MODE) begin
          mode_reg <= sh_next[15:0] & MODE_MASK;
        end else if (addr_reg == ADDR_IFMODE) begin
          ifmode_reg <= sh_next[15:0] & IFMODE_MASK;
        end else if (addr_reg[5:2] == ADDR_CH0[5:2]) begin
          ch_reg[addr_reg[1:0]] <= sh_next[15:0] & CH_MASK;
        end else if (addr_reg[5:2] == ADDR_SETUP0[5:2]) begin
          // polarity and reference fields only
          setup_reg[addr_reg[1:0]] <= sh_next[15:0] & SETUP_MASK;
        end else if (addr_reg[5:2] == ADDR_FILT0[5:2]) begin
          filt_reg[addr_reg[1:0]] <= sh_next[15:0] & FILT_MASK;
        end else if (addr_reg[5:2] == ADDR_OFFS0[5:2]) begin
          offs_reg[addr_reg[1:0]] <= sh_next;
        end else if (addr_reg[5:2] == ADDR_SETUP_ZERO_GAIN_COEFFICIENT[5:2]) begin
          gain_reg[addr_reg[1:0]] <= sh_next;
        end
      end
      if (cal_fire) begin
        if (cal_gain_reg) begin
          gain_reg[cal_setup_reg] <= cal_val_reg;
        end else begin
          offs_reg[cal_setup_reg] <= cal_val_reg;
        end
      end
    end
  end

  // calibration words are held steady in the system domain until acked
  assign cal_fire = cal_tog_s ^ cal_seen_reg;

  always_ff @(posedge sclk_i) begin
    if (rst_s) begin
      cal_seen_reg <= 1'b0;
      full_tog_reg <= 1'b0;
    end else begin
      cal_seen_reg <= cal_tog_s;
      if (full_rst) begin
        full_tog_reg <= !full_tog_reg;
      end
    end
  end

  // ********************************
  // system domain
  // ********************************
  // limitation: a calibration load needs running serial clock edges
  assign cal_busy_o = cal_tog_reg ^ cal_ack_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_tog_reg   <= 1'b0;
      cal_gain_reg  <= 1'b0;
      cal_setup_reg <= '0;
      cal_val_reg   <= '0;
    end else if (cal_req_i && !cal_busy_o) begin
      cal_tog_reg   <= !cal_tog_reg;
      cal_gain_reg  <= cal_gain_i;
      cal_setup_reg <= cal_setup_i;
      cal_val_reg   <= cal_value_i;
    end
  end

  // next enabled channel above start, wrapping
  function automatic logic [1:0] acb_next(input logic [3:0] en,
                                          input logic [1:0] start);
    logic [1:0] k;
    logic       hit;
    acb_next = start;
    hit      = 1'b0;
    for (int i = 1; i <= NUM_CH; i++) begin
      k = start + i[1:0];
      if (en[k] && !hit) begin
        acb_next = k;
        hit      = 1'b1;
      end
    end
  endfunction : acb_next

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_seen_reg <= 1'b0;
      cur_reg       <= LAST_CH;
      valid_reg     <= 1'b0;
    end else begin
      full_seen_reg <= full_tog_s;
      if (full_tog_s != full_seen_reg) begin
        cur_reg   <= LAST_CH;
        valid_reg <= 1'b0;
      end else if (en_s == '0) begin
        valid_reg <= 1'b0;
      end else if (!valid_reg || conv_done_i || !en_s[cur_reg]) begin
        cur_reg   <= acb_next(en_s, valid_reg ? cur_reg : LAST_CH);
        valid_reg <= 1'b1;
      end
    end
  end

  assign active_ch_o    = cur_reg;
  assign active_valid_o = valid_reg;

  // ********************************
  // checks
  // ********************************
  ones_full_reset_a: assert property (@(posedge sclk_i) disable iff (rst_s)
    (!cs_n_i && ones_reg == ONES_LAST && mosi_i) |=>
      (ch_reg[0] == CH0_RST && offs_reg[1] == OFFS_RST))
    else $error("long ones run did not reset the bank");
  cs_idle_a: assert property (@(posedge sclk_i) disable iff (rst_s)
    cs_n_i |-> (phase_reg == ACB_CMD && cnt_reg == '0))
    else $error("port not idle while deselected");
  cmd_decode_a: assert property (@(posedge sclk_i) disable iff (rst_s || cs_n_i)
    (cmd_done && !bank_rst && !sh_next[CMD_WEN_BIT]) |=>
      (phase_reg == ACB_DATA && addr_reg == $past(sh_next[5:0])
       && rd_reg == $past(sh_next[CMD_RD_BIT])))
    else $error("command byte decoded wrongly");
  back_to_cmd_a: assert property (@(posedge sclk_i) disable iff (rst_s || cs_n_i)
    (data_done && !bank_rst) |=> (phase_reg == ACB_CMD && cnt_reg == '0))
    else $error("port did not return to command phase");
  id_read_a: assert property (@(posedge sclk_i) disable iff (rst_s || cs_n_i)
    (cmd_done && !bank_rst && sh_next[7:0] == {2'b01, ADDR_ID}) |=>
      (tx_reg == {ID_CODE, 8'h00} && len_reg == LEN16))
    else $error("identity read not loaded");
  ch_write_a: assert property (@(posedge sclk_i) disable iff (rst_s || cs_n_i)
    (wr_fire && !bank_rst && addr_reg[5:2] == ADDR_CH0[5:2]) |=>
      (ch_reg[$past(addr_reg[1:0])] == ($past(sh_next[15:0]) & CH_MASK)))
    else $error("channel write lost");
  cal_load_a: assert property (@(posedge sclk_i) disable iff (rst_s)
    (cal_fire && !bank_rst && !cal_gain_reg) |=>
      (offs_reg[$past(cal_setup_reg)] == $past(cal_val_reg)))
    else $error("offset calibration not loaded");
  seq_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (valid_reg && conv_done_i && en_s == 4'hf && $stable(en_s)
     && full_tog_s == full_seen_reg) |=> (cur_reg == $past(cur_reg) + 2'h1))
    else $error("sequencer did not step ascending");
  seq_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (valid_reg && conv_done_i && en_s == 4'h5 && cur_reg == 2'h2
     && full_tog_s == full_seen_reg) |=> (cur_reg == 2'h0))
    else $error("sequencer did not skip and wrap");
endmodule : acb_bank
`default_nettype wire

// [sim/acb_host_model.sv]
/*
 * host side of the serial link: a mode 3 master model.
 * assumes the bank samples mosi on rising sclk and drives miso on falling.
 */
`timescale 1ns/1ns
`default_nettype none
module acb_host_model (
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  localparam int HALF = 32;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ********************************
  // one period: drive on falling, sample at rising
  // ********************************
  task automatic bit_io(input logic b, output logic s);
    sclk_o = 1'b0;
    mosi_o = b;
    #HALF;
    s = miso_i;
    sclk_o = 1'b1;
    #HALF;
  endtask : bit_io
  // command byte msb first, then n data bits
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                      input int n, input bit hold, output logic [23:0] rd);
    logic s;
    cs_n_o = 1'b0;
    #HALF;
    rd = '0;
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], s);
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(wd[i], s);
      rd = {rd[22:0], s};
    end
    // released line shows the inverse so a stale bit never looks valid
    if (!hold) begin
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #HALF;
    end
  endtask : xfer
  // data-in held high for n clocks
  task automatic ones(input int n);
    logic s;
    cs_n_o = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) bit_io(1'b1, s);
    cs_n_o = 1'b1;
    #HALF;
  endtask : ones
  // idle clocks with chip select high, for resets and calibration
  task automatic tick(input int n);
    logic s;
    for (int i = 0; i < n; i++) bit_io(1'b0, s);
  endtask : tick
endmodule : acb_host_model
`default_nettype wire

// [sim/acb_bank_tb.sv]
/*
 * self-checking bench of the channel/setup register bank.
 * assumes acb_pkg, acb_bank and acb_host_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module acb_bank_tb;
  import acb_pkg::*;
  localparam logic [15:0] ID_EXP   = 16'h0a50; // arbitrary value
  localparam logic [23:0] GAIN_EXP = 24'h5c3a10;
  localparam int          LIMIT    = 20000;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        conv_done_i = 1'b0;
  logic        cal_req_i   = 1'b0;
  logic        cal_gain_i  = 1'b0;
  logic [1:0]  cal_setup_i = 2'h0;
  logic [23:0] cal_value_i = 24'h0;
  logic        sclk, cs_n, mosi, miso, miso_oe, valid, busy;
  logic [1:0]  ach;
  int          err_total   = 0;
  int          num_checks  = 0;
  int          cyc         = 0;
  always #25 clk_i = ~clk_i;
  acb_bank #(.ID_CODE(ID_EXP), .GAIN_FACT(GAIN_EXP)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .conv_done_i(conv_done_i), .active_ch_o(ach),
    .active_valid_o(valid), .cal_req_i(cal_req_i),
    .cal_gain_i(cal_gain_i), .cal_setup_i(cal_setup_i),
    .cal_value_i(cal_value_i), .cal_busy_o(busy));
  acb_host_model u_host (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  // ********************************
  // helpers
  // ********************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input int n, input logic [23:0] v);
    logic [23:0] d;
    u_host.xfer({2'b00, a}, v, n, 1'b0, d);
  endtask : wr
  task automatic chk_reg(input string what, input logic [5:0] a,
                         input int n, input logic [23:0] exp);
    logic [23:0] v;
    u_host.xfer({2'b01, a}, 24'h0, n, 1'b0, v);
    check(what, v, exp);
  endtask : chk_reg
  task automatic pulse();
    @(posedge clk_i) conv_done_i <= 1'b1;
    @(posedge clk_i) conv_done_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : pulse
  // ********************************
  // scenarios
  // ********************************
  task automatic t_defaults();
    chk_reg("ch0", ADDR_CH0, 16, 24'h8001);
    chk_reg("ch1", ADDR_CH0 + 6'h1, 16, 24'h0001);
    chk_reg("setup0", ADDR_SETUP0, 16, 24'h1000);
    chk_reg("filt0", ADDR_FILT0, 16, 24'h0);
    chk_reg("offs0", ADDR_OFFS0, 24, 24'h800000);
    chk_reg("setup_zero_gain_coefficient", ADDR_SETUP_ZERO_GAIN_COEFFICIENT, 24, GAIN_EXP);
    chk_reg("mode", ADDR_MODE, 16, 24'h8000);
    chk_reg("ifmode", ADDR_IFMODE, 16, 24'h0);
    check("oe idle", {23'h0, miso_oe}, 24'h0);
  endtask : t_defaults
  task automatic t_id();
    chk_reg("id", ADDR_ID, 16, {8'h0, ID_EXP});
    wr(ADDR_ID, 16, 24'h1234);
    chk_reg("id ro", ADDR_ID, 16, {8'h0, ID_EXP});
    chk_reg("unmapped", 6'h3f, 8, 24'h0);
  endtask : t_id
  task automatic t_rw();
    logic [5:0] o;
    for (int s = 0; s < 4; s++) begin
      o = s[5:0];
      wr(ADDR_SETUP0 + o, 16, 24'hffff);
      chk_reg("setup", ADDR_SETUP0 + o, 16, {8'h0, SETUP_MASK});
      wr(ADDR_FILT0 + o, 16, 24'hffff);
      chk_reg("filt", ADDR_FILT0 + o, 16, {8'h0, FILT_MASK});
      wr(ADDR_OFFS0 + o, 24, {s[3:0], 20'h2468a});
      chk_reg("offs", ADDR_OFFS0 + o, 24, {s[3:0], 20'h2468a});
      wr(ADDR_SETUP_ZERO_GAIN_COEFFICIENT + o, 24, {~s[3:0], 20'h13579});
      chk_reg("gain", ADDR_SETUP_ZERO_GAIN_COEFFICIENT + o, 24, {~s[3:0], 20'h13579});
      wr(ADDR_CH0 + o, 16, 24'hffff);
      chk_reg("chan", ADDR_CH0 + o, 16, {8'h0, CH_MASK});
    end
    chk_reg("offs0 kept", ADDR_OFFS0, 24, 24'h02468a);
    wr(ADDR_MODE, 16, 24'hffff);
    chk_reg("mode wr", ADDR_MODE, 16, {8'h0, MODE_MASK});
    wr(ADDR_IFMODE, 16, 24'hffff);
    chk_reg("ifmode wr", ADDR_IFMODE, 16, {8'h0, IFMODE_MASK});
  endtask : t_rw
  task automatic t_abort_b2b();
    logic [23:0] v;
    wr(ADDR_CH0 + 6'h1, 16, 24'h0005);
    u_host.xfer(8'h11, 24'h00ff, 8, 1'b0, v);
    chk_reg("ch1 abort", ADDR_CH0 + 6'h1, 16, 24'h0005);
    // chip select stays low from here: framing rests on bit counts alone
    u_host.xfer({2'b00, ADDR_FILT0 + 6'h1}, 24'h0a05, 16, 1'b1, v);
    u_host.xfer({2'b01, ADDR_FILT0 + 6'h1}, 24'h0, 16, 1'b1, v);
    check("b2b filt", v, 24'h0a05);
    check("oe on", {23'h0, miso_oe}, 24'h1);
    u_host.xfer({2'b01, ADDR_ID}, 24'h0, 16, 1'b0, v);
    check("b2b id", v, {8'h0, ID_EXP});
  endtask : t_abort_b2b
  task automatic t_full_reset();
    wr(ADDR_CH0, 16, 24'h0);
    wr(ADDR_OFFS0, 24, 24'h0);
    u_host.ones(64);
    chk_reg("ch0 rst", ADDR_CH0, 16, 24'h8001);
    chk_reg("offs0 rst", ADDR_OFFS0, 24, 24'h800000);
    chk_reg("ch2 rst", ADDR_CH0 + 6'h2, 16, 24'h0001);
  endtask : t_full_reset
  task automatic t_seq();
    logic [1:0] e;
    repeat (8) @(posedge clk_i);
    #1;
    check("valid", {23'h0, valid}, 24'h1);
    check("seq start", {22'h0, ach}, 24'h0);
    wr(ADDR_CH0 + 6'h2, 16, 24'h8043);
    repeat (8) @(posedge clk_i);
    pulse();
    check("seq skip", {22'h0, ach}, 24'h2);
    pulse();
    check("seq wrap", {22'h0, ach}, 24'h0);
    wr(ADDR_CH0 + 6'h1, 16, 24'h8000);
    wr(ADDR_CH0 + 6'h3, 16, 24'h8000);
    repeat (8) @(posedge clk_i);
    for (int i = 1; i <= 4; i++) begin
      e = i[1:0];
      pulse();
      check("seq all", {22'h0, ach}, {22'h0, e});
    end
  endtask : t_seq
  task automatic t_cal(input logic g, input logic [1:0] s,
                       input logic [23:0] v, input logic [5:0] a);
    @(posedge clk_i) begin
      cal_req_i   <= 1'b1;
      cal_gain_i  <= g;
      cal_setup_i <= s;
      cal_value_i <= v;
    end
    @(posedge clk_i) cal_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("busy up", {23'h0, busy}, 24'h1);
    u_host.tick(8);
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clk_i);
    check("busy down", {23'h0, busy}, 24'h0);
    chk_reg("cal word", a, 24, v);
  endtask : t_cal
  // ********************************
  // main sequence
  // ********************************
  initial begin
    fork
      u_host.tick(8);
      repeat (20) @(posedge clk_i);
    join
    rst_i <= 1'b0;
    // the bank leaves reset only after sclk carries the release across
    u_host.tick(4);
    t_defaults();
    t_id();
    t_abort_b2b();
    t_rw();
    t_full_reset();
    t_seq();
    t_cal(1'b0, 2'h1, 24'h3c5a96, ADDR_OFFS0 + 6'h1);
    t_cal(1'b1, 2'h3, 24'h5e0d30, ADDR_SETUP_ZERO_GAIN_COEFFICIENT + 6'h3);
    final_report();
  end
endmodule : acb_bank_tb
`default_nettype wire
